// *** hdl/gdf_params.svh ***
`ifndef GDF_PARAMS_SVH
`define GDF_PARAMS_SVH

// Register addresses
`define GDF_ADDR_FAULT1 3'h0
`define GDF_ADDR_FAULT2 3'h1
`define GDF_ADDR_CTL1 3'h2
`define GDF_ADDR_CTL2 3'h3
`define GDF_ADDR_CTL3 3'h4
`define GDF_ADDR_CTL4 3'h5
`define GDF_ADDR_LAST 3'h5

// Frame layout
`define GDF_FRAME_BITS 5'h10
`define GDF_FRAME_OVER 5'h11
`define GDF_HEADER_BITS 5'h04
`define GDF_RW_BIT 15
`define GDF_ADDR_HI 14
`define GDF_ADDR_LO 12

// Control word defaults
`define GDF_CTL1_DEFAULT 12'h3a4
`define GDF_CTL2_DEFAULT 12'h250
`define GDF_CTL3_DEFAULT 12'hb02
`define GDF_CTL4_DEFAULT 12'h7fc

// Control word one fields
`define GDF_C1_CLEAR 11
`define GDF_C1_LOCK_HI 10
`define GDF_C1_LOCK_LO 8
`define GDF_C1_PUMP_EN 7
`define GDF_C1_WARN_ROUTE 5
`define GDF_LOCK_ON 3'h6
`define GDF_LOCK_OFF 3'h3

// Control word two fields
`define GDF_C2_DS_MODE_HI 11
`define GDF_C2_DS_MODE_LO 10
`define GDF_C2_DEG_HI 5
`define GDF_C2_DEG_LO 4
`define GDF_C2_DS_DELAY 3
`define GDF_C2_CS_DELAY 2
`define GDF_C2_CS_MODE_HI 1
`define GDF_C2_CS_MODE_LO 0

// Control word three calibration field
`define GDF_C3_CAL_HI 6
`define GDF_C3_CAL_LO 4
`define GDF_C3_CAL_MASK 12'h070

// Response mode codes
`define GDF_RESP_LATCH 2'h0
`define GDF_RESP_RETRY 2'h1
`define GDF_RESP_IGNORE 2'h3

// Fault word one bits, reserved masks of both fault words
`define GDF_F1_SUMMARY 11
`define GDF_F1_SUPPLY_UV 10
`define GDF_F1_PUMP_UV 8
`define GDF_F1_DS_OC 7
`define GDF_F1_CS_OC 6
`define GDF_F1_WARN 5
`define GDF_F1_TSD 4
`define GDF_F1_REG_OC 2
`define GDF_F1_REG_UV 1
`define GDF_F1_REG_OV 0
`define GDF_F1_RSVD_MASK 12'h208
`define GDF_F2_RSVD_MASK 12'h007

// Timing
`define GDF_CLK_PERIOD_NS 40
`define GDF_DEG0_NS 1400
`define GDF_DEG1_NS 2200
`define GDF_DEG2_NS 3200
`define GDF_DEG3_NS 5400
`define GDF_RETRY_SHORT_NS 70000
`define GDF_RETRY_LONG_NS 4000000
`define GDF_RETRY_W 17

`endif

// *** hdl/gdf_pkg.sv ***
package gdf_pkg;

    typedef enum logic [1:0] {PROT_RUN, PROT_LATCHED, PROT_RETRY} gdf_prot_state_type;

    typedef struct packed {
        logic supply_undervoltage;
        logic pump_undervoltage;
        logic thermal_warning;
        logic thermal_shutdown;
        logic regulator_overcurrent;
        logic regulator_undervoltage;
        logic regulator_overvoltage;
        logic [2:0] amp_overcurrent;
        logic [5:0] phase_overcurrent;
    } gdf_fault_in_type;

    typedef struct packed {
        logic [11:0] word_one;
        logic [11:0] word_two;
        logic [11:0] word_three;
        logic [11:0] word_four;
    } gdf_config_type;

endpackage : gdf_pkg

// *** hdl/gdf_regs.sv ***
// Functional notes
// - Sleep or shutdown returns all four control words to defaults.
// - Summary fault bit sets on any fault except thermal warning or an ignored overcurrent; cleared by clear command or enable low.
// - Thermal warning bit follows the warning level, no software clear needed.
// - Fault word one latches supply, pump, overcurrent, shutdown, regulator events.
// - Fault word two latches per-amplifier and per-transistor overcurrent detail.
// - Writing 1 to control word one bit 11 clears faults, reads back 0.
// - Lock code 110 blocks writes except lock field; 011 unlocks; others ignored.
// - Pump protect enable chooses shutdown action or report only on pump undervoltage.
// - Thermal warning routing chooses fault pin plus flag or flag only.
// - Input scheme, sensing method and hold enables sit in control word one.
// - Two-bit crossover gap code selects 100, 150, 250 or 450 ns.
// - Drain-source response: latch, retry, report only, or ignore without summary.
// - Four-bit drain-source threshold code, default 1001.
// - Deglitch code selects 1.4, 2.2, 3.2 or 5.4 us for both detectors.
// - Retry delay bits select 4 ms or 70 us per detector.
// - Sense response: latch, retry, report only, or ignore without summary.
// - Three-bit sense threshold code, default 101.
// - Current amplifier gain code, default 10.
// - Calibration start bits set by writing 1, self-clear when calibration ends.
// - Back-EMF enable, back-EMF gain and common select in control word three.
// - Gate transition time, calibration connect and comparator mode in word four.
// - High and low drive strength codes, both default 1111.
// - Frame is 16 bits MSB first: read flag, 3-bit address, 12 data bits.
// - Frames with address above 5 or length not 16 are ignored.
// - Capture on falling serial clock, launch on rising; writes return old content.
`timescale 1ns/1ps
`default_nettype none
`include "gdf_params.svh"

module gdf_regs #(
    parameter int RETRY_LONG_CYCLES = `GDF_RETRY_LONG_NS / `GDF_CLK_PERIOD_NS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic serial_select_n,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    input wire logic enable_pin,
    input wire logic low_power_enter,
    input wire gdf_pkg::gdf_fault_in_type fault_in,
    input wire logic [2:0] calibration_done,
    output gdf_pkg::gdf_config_type config_out,
    output logic error_output_pin_n,
    output logic drive_disable
);
    import gdf_pkg::*;

    localparam int DEG0 = (`GDF_DEG0_NS + `GDF_CLK_PERIOD_NS - 1) / `GDF_CLK_PERIOD_NS;
    localparam int DEG1 = (`GDF_DEG1_NS + `GDF_CLK_PERIOD_NS - 1) / `GDF_CLK_PERIOD_NS;
    localparam int DEG2 = (`GDF_DEG2_NS + `GDF_CLK_PERIOD_NS - 1) / `GDF_CLK_PERIOD_NS;
    localparam int DEG3 = (`GDF_DEG3_NS + `GDF_CLK_PERIOD_NS - 1) / `GDF_CLK_PERIOD_NS;
    localparam int RETRY_SHORT_CYCLES = `GDF_RETRY_SHORT_NS / `GDF_CLK_PERIOD_NS;

    function automatic logic [7:0] deg_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: deg_cycles = 8'(DEG0);
            2'h1: deg_cycles = 8'(DEG1);
            2'h2: deg_cycles = 8'(DEG2);
            2'h3: deg_cycles = 8'(DEG3);
        endcase
    endfunction : deg_cycles

    function automatic logic [`GDF_RETRY_W-1:0] retry_load(input logic short_sel);
        retry_load = short_sel ? `GDF_RETRY_W'(RETRY_SHORT_CYCLES - 1)
                               : `GDF_RETRY_W'(RETRY_LONG_CYCLES - 1);
    endfunction : retry_load

    function automatic gdf_prot_state_type next_prot(input gdf_prot_state_type st,
            input logic evt, input logic [1:0] mode, input logic done, input logic clr);
        next_prot = st;
        unique case (st)
            PROT_RUN: begin
                if (evt && mode == `GDF_RESP_LATCH) begin
                    next_prot = PROT_LATCHED;
                end else if (evt && mode == `GDF_RESP_RETRY) begin
                    next_prot = PROT_RETRY;
                end
            end
            PROT_LATCHED: begin
                if (clr) begin
                    next_prot = PROT_RUN;
                end
            end
            PROT_RETRY: begin
                if (done) begin
                    next_prot = PROT_RUN;
                end
            end
            default: next_prot = PROT_RUN;
        endcase
    endfunction : next_prot

    // Pin synchronisers; the third stage only serves edge detection
    logic [2:0] sclk_sync;
    logic [2:0] sel_sync;
    logic [1:0] sdi_sync;
    logic [1:0] en_sync;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sclk_sync <= 3'h0;
            sel_sync <= 3'h7;
            sdi_sync <= 2'h0;
            en_sync <= 2'h3;
        end else begin
            sclk_sync <= {sclk_sync[1:0], serial_clock};
            sel_sync <= {sel_sync[1:0], serial_select_n};
            sdi_sync <= {sdi_sync[0], serial_data_in};
            en_sync <= {en_sync[0], enable_pin};
        end
    end

    wire selected = !sel_sync[1];
    wire sclk_fall = selected && sclk_sync[2] && !sclk_sync[1];
    wire sclk_rise = selected && !sclk_sync[2] && sclk_sync[1];
    wire frame_end = sel_sync[1] && !sel_sync[2];

    // Frame shifter
    logic [15:0] rx_shift;
    logic [4:0] bit_count;
    logic [11:0] tx_shift;

    wire [2:0] rx_addr = rx_shift[`GDF_ADDR_HI:`GDF_ADDR_LO];
    wire [11:0] rx_data = rx_shift[11:0];
    wire addr_ok = rx_addr <= `GDF_ADDR_LAST;
    wire frame_ok = frame_end && bit_count == `GDF_FRAME_BITS && addr_ok;
    wire write_cmd = frame_ok && !rx_shift[`GDF_RW_BIT];
    wire header_done = sclk_fall && bit_count == `GDF_HEADER_BITS - 5'h01;
    wire [2:0] head_addr = {rx_shift[1:0], sdi_sync[1]};

    // Register storage
    logic [11:0] fault_one;
    logic [11:0] fault_two;
    logic [11:0] ctl_one;
    logic [11:0] ctl_two;
    logic [11:0] ctl_three;
    logic [11:0] ctl_four;

    function automatic logic [11:0] reg_read(input logic [2:0] addr);
        unique case (addr)
            `GDF_ADDR_FAULT1: reg_read = fault_one & ~`GDF_F1_RSVD_MASK;
            `GDF_ADDR_FAULT2: reg_read = fault_two & ~`GDF_F2_RSVD_MASK;
            `GDF_ADDR_CTL1: reg_read = ctl_one;
            `GDF_ADDR_CTL2: reg_read = ctl_two;
            `GDF_ADDR_CTL3: reg_read = ctl_three;
            `GDF_ADDR_CTL4: reg_read = ctl_four;
            default: reg_read = 12'h000;
        endcase
    endfunction : reg_read

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_shift <= 16'h0000;
            bit_count <= 5'h00;
        end else if (!selected) begin
            bit_count <= 5'h00;
        end else if (sclk_fall) begin
            rx_shift <= {rx_shift[14:0], sdi_sync[1]};
            if (bit_count != `GDF_FRAME_OVER) begin
                bit_count <= bit_count + 5'h01;
            end
        end
    end

    // Old content goes out after the address, for reads and writes alike
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_shift <= 12'h000;
            serial_data_out <= 1'b0;
            serial_data_out_oe <= 1'b0;
        end else begin
            serial_data_out_oe <= selected;
            if (!selected) begin
                serial_data_out <= 1'b0;
            end else if (header_done) begin
                tx_shift <= reg_read(head_addr);
            end else if (sclk_rise && bit_count >= `GDF_HEADER_BITS) begin
                serial_data_out <= tx_shift[11];
                tx_shift <= {tx_shift[10:0], 1'b0};
            end
        end
    end

    // Write decode
    wire locked = ctl_one[`GDF_C1_LOCK_HI:`GDF_C1_LOCK_LO] == `GDF_LOCK_ON;
    wire [2:0] new_lock = rx_data[`GDF_C1_LOCK_HI:`GDF_C1_LOCK_LO];
    wire lock_code_ok = new_lock == `GDF_LOCK_ON || new_lock == `GDF_LOCK_OFF;
    wire wr_open = write_cmd && !locked;
    wire wr_one = wr_open && rx_addr == `GDF_ADDR_CTL1;
    wire wr_lock = write_cmd && rx_addr == `GDF_ADDR_CTL1 && lock_code_ok;
    wire wr_two = wr_open && rx_addr == `GDF_ADDR_CTL2;
    wire wr_three = wr_open && rx_addr == `GDF_ADDR_CTL3;
    wire wr_four = wr_open && rx_addr == `GDF_ADDR_CTL4;
    wire clear_cmd = wr_one && rx_data[`GDF_C1_CLEAR];
    wire clear_any = clear_cmd || !en_sync[1];
    wire [2:0] cal_set = wr_three ? rx_data[`GDF_C3_CAL_HI:`GDF_C3_CAL_LO] : 3'h0;
    wire [2:0] cal_now = ctl_three[`GDF_C3_CAL_HI:`GDF_C3_CAL_LO];
    wire [2:0] next_cal = (cal_now & ~calibration_done) | cal_set;

    logic [11:0] next_ctl_one;
    always_comb begin
        next_ctl_one = ctl_one;
        if (wr_one) begin
            next_ctl_one = rx_data;
            next_ctl_one[`GDF_C1_LOCK_HI:`GDF_C1_LOCK_LO] =
                ctl_one[`GDF_C1_LOCK_HI:`GDF_C1_LOCK_LO];
        end
        if (wr_lock) begin
            next_ctl_one[`GDF_C1_LOCK_HI:`GDF_C1_LOCK_LO] = new_lock;
        end
        next_ctl_one[`GDF_C1_CLEAR] = 1'b0;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctl_one <= `GDF_CTL1_DEFAULT;
            ctl_two <= `GDF_CTL2_DEFAULT;
            ctl_three <= `GDF_CTL3_DEFAULT;
            ctl_four <= `GDF_CTL4_DEFAULT;
        end else if (low_power_enter) begin
            ctl_one <= `GDF_CTL1_DEFAULT;
            ctl_two <= `GDF_CTL2_DEFAULT;
            ctl_three <= `GDF_CTL3_DEFAULT;
            ctl_four <= `GDF_CTL4_DEFAULT;
        end else begin
            ctl_one <= next_ctl_one;
            if (wr_two) begin
                ctl_two <= rx_data;
            end
            ctl_three <= wr_three ? rx_data : ctl_three;
            ctl_three[`GDF_C3_CAL_HI:`GDF_C3_CAL_LO] <= next_cal;
            if (wr_four) begin
                ctl_four <= rx_data;
            end
        end
    end

    // Overcurrent deglitch; a level that outlasts the window fires one event
    logic [7:0] ds_glitch;
    logic [7:0] cs_glitch;
    wire [7:0] deg_target = deg_cycles(ctl_two[`GDF_C2_DEG_HI:`GDF_C2_DEG_LO]);
    wire ds_raw = |fault_in.phase_overcurrent;
    wire cs_raw = |fault_in.amp_overcurrent;
    wire ds_evt = ds_raw && ds_glitch == deg_target - 8'h01;
    wire cs_evt = cs_raw && cs_glitch == deg_target - 8'h01;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ds_glitch <= 8'h00;
            cs_glitch <= 8'h00;
        end else begin
            ds_glitch <= !ds_raw ? 8'h00 : (ds_glitch == deg_target ? ds_glitch : ds_glitch + 8'h01);
            cs_glitch <= !cs_raw ? 8'h00 : (cs_glitch == deg_target ? cs_glitch : cs_glitch + 8'h01);
        end
    end

    // Response modes
    wire [1:0] ds_mode = ctl_two[`GDF_C2_DS_MODE_HI:`GDF_C2_DS_MODE_LO];
    wire [1:0] cs_mode = ctl_two[`GDF_C2_CS_MODE_HI:`GDF_C2_CS_MODE_LO];
    gdf_prot_state_type ds_state;
    gdf_prot_state_type cs_state;
    logic [`GDF_RETRY_W-1:0] ds_timer;
    logic [`GDF_RETRY_W-1:0] cs_timer;
    wire gdf_prot_state_type next_ds = next_prot(ds_state, ds_evt, ds_mode,
        ds_timer == '0, clear_any);
    wire gdf_prot_state_type next_cs = next_prot(cs_state, cs_evt, cs_mode,
        cs_timer == '0, clear_any);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ds_state <= PROT_RUN;
            cs_state <= PROT_RUN;
            ds_timer <= '0;
            cs_timer <= '0;
        end else begin
            ds_state <= next_ds;
            cs_state <= next_cs;
            if (ds_state == PROT_RUN && next_ds == PROT_RETRY) begin
                ds_timer <= retry_load(ctl_two[`GDF_C2_DS_DELAY]);
            end else if (ds_timer != '0) begin
                ds_timer <= ds_timer - 1'b1;
            end
            if (cs_state == PROT_RUN && next_cs == PROT_RETRY) begin
                cs_timer <= retry_load(ctl_two[`GDF_C2_CS_DELAY]);
            end else if (cs_timer != '0) begin
                cs_timer <= cs_timer - 1'b1;
            end
        end
    end

    // Fault latching; a new event wins over a clear in the same cycle
    wire ds_report = ds_evt && ds_mode != `GDF_RESP_IGNORE;
    wire cs_report = cs_evt && cs_mode != `GDF_RESP_IGNORE;
    logic [11:0] set_one;
    always_comb begin
        set_one = 12'h000;
        set_one[`GDF_F1_SUPPLY_UV] = fault_in.supply_undervoltage;
        set_one[`GDF_F1_PUMP_UV] = fault_in.pump_undervoltage;
        set_one[`GDF_F1_DS_OC] = ds_evt;
        set_one[`GDF_F1_CS_OC] = cs_evt;
        set_one[`GDF_F1_TSD] = fault_in.thermal_shutdown;
        set_one[`GDF_F1_REG_OC] = fault_in.regulator_overcurrent;
        set_one[`GDF_F1_REG_UV] = fault_in.regulator_undervoltage;
        set_one[`GDF_F1_REG_OV] = fault_in.regulator_overvoltage;
        set_one[`GDF_F1_SUMMARY] = fault_in.supply_undervoltage || fault_in.pump_undervoltage
            || fault_in.thermal_shutdown || fault_in.regulator_overcurrent
            || fault_in.regulator_undervoltage || fault_in.regulator_overvoltage
            || ds_report || cs_report;
    end
    wire [11:0] set_two = {fault_in.amp_overcurrent & {3{cs_evt}},
        fault_in.phase_overcurrent & {6{ds_evt}}, 3'h0};
    wire [11:0] next_fault_one = ((clear_any ? 12'h000 : fault_one) | set_one)
        & ~`GDF_F1_RSVD_MASK;
    wire [11:0] next_fault_two = (clear_any ? 12'h000 : fault_two) | set_two;
    wire warn_to_pin = fault_in.thermal_warning && ctl_one[`GDF_C1_WARN_ROUTE];
    wire pump_trip = fault_in.pump_undervoltage && ctl_one[`GDF_C1_PUMP_EN];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_one <= 12'h000;
            fault_two <= 12'h000;
            error_output_pin_n <= 1'b1;
            drive_disable <= 1'b0;
        end else begin
            fault_one <= next_fault_one;
            fault_one[`GDF_F1_WARN] <= fault_in.thermal_warning;
            fault_two <= next_fault_two;
            error_output_pin_n <= !(next_fault_one[`GDF_F1_SUMMARY] || warn_to_pin);
            drive_disable <= pump_trip || next_ds != PROT_RUN || next_cs != PROT_RUN;
        end
    end

    assign config_out = '{word_one: ctl_one, word_two: ctl_two, word_three: ctl_three,
        word_four: ctl_four};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_LOWPOWER_DEFAULTS: assert property (low_power_enter |=> ctl_two == `GDF_CTL2_DEFAULT
        && ctl_four == `GDF_CTL4_DEFAULT && ctl_one == `GDF_CTL1_DEFAULT)
        else $error("control words not at defaults after low power entry");
    AST_SUMMARY_STICKS: assert property (fault_one[`GDF_F1_SUMMARY] && !clear_any
        |=> fault_one[`GDF_F1_SUMMARY]) else $error("summary fault dropped without a clear");
    AST_WARN_FOLLOWS: assert property (##1 fault_one[`GDF_F1_WARN]
        == $past(fault_in.thermal_warning)) else $error("warning flag not tracking level");
    AST_RESERVED_ZERO: assert property ((reg_read(`GDF_ADDR_FAULT1) & `GDF_F1_RSVD_MASK) == 0
        && (reg_read(`GDF_ADDR_FAULT2) & `GDF_F2_RSVD_MASK) == 0)
        else $error("reserved fault bit reads one");
    AST_CLEAR_READS_ZERO: assert property (clear_cmd |=> !ctl_one[`GDF_C1_CLEAR]
        && (fault_two == $past(set_two))) else $error("clear command misbehaved");
    AST_LOCK_BLOCKS: assert property (locked && write_cmd && rx_addr == `GDF_ADDR_CTL4
        |=> $stable(ctl_four) || $past(low_power_enter)) else $error("write passed the lock");
    AST_PUMP_ACTION: assert property (pump_trip |=> drive_disable ##0 !error_output_pin_n)
        else $error("pump undervoltage without action");
    AST_WARN_PIN: assert property (warn_to_pin |=> !error_output_pin_n)
        else $error("routed warning missing on fault pin");
    AST_DS_IGNORE_DETAIL: assert property (ds_evt && ds_mode == `GDF_RESP_IGNORE
        |=> fault_one[`GDF_F1_DS_OC] && ds_state == PROT_RUN) else $error("ignore mode wrong");
    AST_CS_RETRY_SHORT: assert property (cs_state == PROT_RUN && next_cs == PROT_RETRY
        && ctl_two[`GDF_C2_CS_DELAY] |=> cs_timer == `GDF_RETRY_W'(RETRY_SHORT_CYCLES - 1))
        else $error("sense retry delay not loaded");
    AST_BAD_FRAME_IGNORED: assert property (frame_end && !frame_ok && !low_power_enter
        && calibration_done == 3'h0 |=> $stable(ctl_two) && $stable(ctl_four))
        else $error("bad frame changed a register");
    AST_CAL_SELF_CLEAR: assert property (calibration_done[0] && !cal_set[0] && !low_power_enter
        |=> !ctl_three[`GDF_C3_CAL_LO]) else $error("calibration bit did not clear");

    COV_WRITE_FRAME: cover property (write_cmd && rx_addr == `GDF_ADDR_CTL2);
    COV_READ_FRAME: cover property (frame_ok && rx_shift[`GDF_RW_BIT]);
    COV_CS_RETRY: cover property (cs_state == PROT_RETRY ##1 cs_state == PROT_RUN);
    COV_LOCKED_WRITE: cover property (locked && wr_lock);

endmodule : gdf_regs

`default_nettype wire

// *** verif/gdf_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module gdf_host (
    input wire logic mclk,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic sel_n,
    output logic sck,
    output logic sdi
);
    // Pull-down holds the released line low
    wire logic line = sdo_oe & sdo;
    initial begin
        sel_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // Bit counts other than 16 only for refused frames
    task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
        r = 16'h0000;
        @(posedge mclk) sel_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < nb; i++) begin
            sdi <= w[15 - i];
            sck <= 1'b1;
            repeat (4) @(posedge mclk);
            sck <= 1'b0;
            @(posedge mclk);
            @(negedge mclk);
            r = {r[14:0], line};
            // Low phase matches the high phase, so the link clock period is 320 ns
            repeat (3) @(posedge mclk);
        end
        sel_n <= 1'b1;
        sdi <= ~sdi;
        repeat (14) @(posedge mclk);
    endtask : xfer
endmodule : gdf_host
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gdf_pkg::*;
    logic mclk, resetn, sel_n, sck, sdi, sdo, sdo_oe, enable_pin, low_power_enter;
    logic error_output_pin_n, drive_disable;
    logic [2:0] calibration_done;
    logic [15:0] rv;
    gdf_fault_in_type fault_in;
    gdf_config_type config_out;
    int fails = 0, n_tests = 0, cycles = 0;
    logic [11:0] dflt [6] = '{12'h000, 12'h000, 12'h3a4, 12'h250, 12'hb02, 12'h7fc};
    gdf_regs #(.RETRY_LONG_CYCLES(200)) gdf_regs_i (.mclk(mclk), .resetn(resetn),
        .serial_select_n(sel_n), .serial_clock(sck), .serial_data_in(sdi),
        .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .enable_pin(enable_pin),
        .low_power_enter(low_power_enter), .fault_in(fault_in),
        .calibration_done(calibration_done), .config_out(config_out),
        .error_output_pin_n(error_output_pin_n), .drive_disable(drive_disable));
    gdf_host gdf_host_i (.mclk(mclk), .sdo(sdo), .sdo_oe(sdo_oe), .sel_n(sel_n), .sck(sck),
        .sdi(sdi));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic report_and_stop();
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    // A hung frame would otherwise run forever
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [11:0] d);
        gdf_host_i.xfer({1'b0, a, d}, 16, rv);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [11:0] e);
        gdf_host_i.xfer({1'b1, a, 12'h000}, 16, rv);
        chk(rv, {4'h0, e});
    endtask : rd
    // Pin is picked by a flag so that it is read after the wait, not at the call
    task automatic pin(input logic drv, input logic e);
        repeat (3) @(posedge mclk);
        chk({15'h0, drv ? drive_disable : error_output_pin_n}, {15'h0, e});
    endtask : pin
    initial begin
        resetn = 1'b0;
        enable_pin = 1'b1;
        low_power_enter = 1'b0;
        fault_in = '0;
        calibration_done = 3'h0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int a = 0; a < 6; a++) rd(a[2:0], dflt[a]);
        wr(3'h3, 12'h123);
        chk(rv, 16'h0250);
        chk({4'h0, config_out.word_two}, 16'h0123);
        wr(3'h6, 12'h000);
        gdf_host_i.xfer(16'h3abc, 15, rv);
        rd(3'h3, 12'h123);
        wr(3'h2, 12'h6a4);
        wr(3'h3, 12'hfff);
        rd(3'h3, 12'h123);
        wr(3'h2, 12'h2a4);
        rd(3'h2, 12'h6a4);
        wr(3'h2, 12'h3a4);
        wr(3'h3, 12'hc50);
        rd(3'h3, 12'hc50);
        @(posedge mclk) fault_in.supply_undervoltage <= 1'b1;
        @(posedge mclk) fault_in.supply_undervoltage <= 1'b0;
        pin(1'b0, 1'b0);
        wr(3'h0, 12'h000);
        rd(3'h0, 12'hc00);
        wr(3'h2, 12'hba4);
        rd(3'h2, 12'h3a4);
        rd(3'h0, 12'h000);
        @(posedge mclk) fault_in.thermal_warning <= 1'b1;
        pin(1'b0, 1'b0);
        rd(3'h0, 12'h020);
        @(posedge mclk) fault_in.thermal_warning <= 1'b0;
        rd(3'h0, 12'h000);
        @(posedge mclk) fault_in.phase_overcurrent <= 6'h20;
        repeat (60) @(posedge mclk);
        fault_in.phase_overcurrent <= 6'h00;
        pin(1'b1, 1'b0);
        rd(3'h0, 12'h080);
        rd(3'h1, 12'h100);
        @(posedge mclk) enable_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        enable_pin <= 1'b1;
        rd(3'h1, 12'h000);
        @(posedge mclk) fault_in.amp_overcurrent <= 3'h4;
        repeat (60) @(posedge mclk);
        fault_in.amp_overcurrent <= 3'h0;
        pin(1'b1, 1'b1);
        rd(3'h0, 12'h840);
        rd(3'h1, 12'h800);
        wr(3'h2, 12'hba4);
        pin(1'b1, 1'b0);
        wr(3'h4, 12'hb52);
        rd(3'h4, 12'hb52);
        @(posedge mclk) calibration_done <= 3'h5;
        @(posedge mclk) calibration_done <= 3'h0;
        rd(3'h4, 12'hb02);
        @(posedge mclk) low_power_enter <= 1'b1;
        @(posedge mclk) low_power_enter <= 1'b0;
        rd(3'h3, 12'h250);
        @(posedge mclk) fault_in.pump_undervoltage <= 1'b1;
        pin(1'b1, 1'b1);
        fault_in.pump_undervoltage <= 1'b0;
        pin(1'b1, 1'b0);
        rd(3'h0, 12'h900);
        wr(3'h3, 12'h255);
        @(posedge mclk) fault_in.amp_overcurrent <= 3'h2;
        repeat (60) @(posedge mclk);
        fault_in.amp_overcurrent <= 3'h0;
        pin(1'b1, 1'b1);
        repeat (1650) @(posedge mclk);
        pin(1'b1, 1'b1);
        repeat (120) @(posedge mclk);
        pin(1'b1, 1'b0);
        rd(3'h1, 12'h400);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
